// ---- hdl/sarrd_pkg.sv ----
/*
  package for the serial readout host controller: frame lengths, edge counts and timing.
  assumes a 25 MHz core clock; all times are converted to core cycles here.
*/
package sarrd_pkg;
  // ==========================================================================
  // clock and timing
  localparam int CORE_CLK_MHZ        = 25;
  localparam int CORE_PERIOD_NS      = 1000 / CORE_CLK_MHZ;
  localparam int SCLK_HALF_CYC       = 4;
  localparam int SCLK_MAX_MHZ        = 20;
  localparam int BUS_IDLE_GAP_NS     = 50;
  localparam int SAMPLE_TRACK_NS     = 225;
  localparam int BUS_IDLE_GAP_CYC    = (BUS_IDLE_GAP_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int SAMPLE_TRACK_CYC    = (SAMPLE_TRACK_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int PDN_RATE_KSPS       = 333;
  // ==========================================================================
  // frame edge counts
  localparam logic [4:0] FULL_EDGES      = 5'h10;
  localparam logic [4:0] EDGES_12BIT     = 5'h10;
  localparam logic [4:0] EDGES_10BIT     = 5'h0e;
  localparam logic [4:0] EDGES_8BIT      = 5'h0c;
  localparam logic [4:0] PDN_EDGES       = 5'h05;
  localparam logic [4:0] SHORT_DUMMY     = 5'h0a;
  localparam logic [4:0] LEAD_ZEROS      = 5'h04;
  localparam logic [4:0] PDN_WIN_LO      = 5'h02;
  localparam logic [4:0] PDN_WIN_HI      = 5'h0a;
  localparam logic [4:0] TRACK_12BIT     = 5'h0d;
  localparam logic [4:0] TRACK_8BIT      = 5'h0b;
  localparam logic [3:0] SHIFT_W         = 4'hf;
  // ==========================================================================
  // commands and variants
  typedef enum logic [1:0] {SARRD_CMD_CONVERT, SARRD_CMD_DUMMY, SARRD_CMD_SHORT_DUMMY,
                            SARRD_CMD_POWER_DOWN} sarrd_cmd_t;
  typedef enum logic [1:0] {SARRD_VAR_12, SARRD_VAR_10, SARRD_VAR_8} sarrd_var_t;
endpackage

// ---- hdl/sarrd_clkdiv.sv ----
/*
  serial clock divider: toggles the serial clock every SCLK_HALF_CYC core cycles while enabled.
  assumes one core clock; emits one-cycle enables for the rising and falling edges it makes.
*/
`timescale 1ns/1ps
module sarrd_clkdiv
  import sarrd_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic srst,
  input  wire logic run,
  output logic      sclk,
  output logic      rise_en,
  output logic      fall_en
);
  // ==========================================================================
  // divider
  logic [2:0] cnt;
  wire        half_done = (cnt == 3'(SCLK_HALF_CYC - 1));

  // idles high so the frame starts with the clock high; the clock is still low when select rises and goes high one cycle later
  always_ff @(posedge core_clk)
  begin
    if (srst || !run)
    begin
      cnt     <= 3'h0;
      sclk    <= 1'b1;
      rise_en <= 1'b0;
      fall_en <= 1'b0;
    end
    else
    begin
      cnt     <= half_done ? 3'h0 : cnt + 3'h1;
      rise_en <= half_done && !sclk;
      fall_en <= half_done && sclk;
      if (half_done)
        sclk <= !sclk;
    end
  end
endmodule // sarrd_clkdiv

// ---- hdl/sarrd_host.sv ----
/*
  host controller driving a serial successive-approximation converter: frame select,
  serial clock, capture of the data line, dummy and power-down frames.
  assumes the converter output arrives asynchronously on dout_line; user side on core_clk.
*/
`timescale 1ns/1ps
module sarrd_host
  import sarrd_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic        req_valid,
  input  wire logic [1:0]  req_cmd,
  input  wire logic [1:0]  variant,
  input  wire logic        rise_capture,
  output logic             req_ready,
  output logic             rsp_valid,
  output logic [11:0]      rsp_data,
  output logic             powered_down,
  output logic             frame_select_n,
  output logic             ser_clk,
  input  wire logic        dout_line
);
  // ==========================================================================
  // state
  typedef enum logic [2:0] {SARRD_IDLE, SARRD_LEAD, SARRD_FRAME, SARRD_GAP,
                            SARRD_DONE} sarrd_state_t;
  sarrd_state_t state;
  sarrd_cmd_t   cmd;
  logic [4:0]   edges;
  logic [4:0]   target;
  logic [15:0]  shreg;
  logic [5:0]   gap_cnt;
  logic         dout_meta;
  logic         dout_sync;
  logic         run;
  logic         sclk_int;
  logic         rise_en;
  logic         fall_en;

  sarrd_clkdiv u_div
  (
    .core_clk (core_clk),
    .srst     (srst),
    .run      (run),
    .sclk     (sclk_int),
    .rise_en  (rise_en),
    .fall_en  (fall_en)
  );

  // ==========================================================================
  // decode
  wire sarrd_cmd_t  in_cmd      = sarrd_cmd_t'(req_cmd);
  wire sarrd_var_t  in_var      = sarrd_var_t'(variant);
  wire logic [4:0]  conv_edges  = (in_var == SARRD_VAR_8)  ? EDGES_8BIT :
                                  (in_var == SARRD_VAR_10) ? EDGES_10BIT :
                                  EDGES_12BIT;
  wire logic [4:0]  next_target = (in_cmd == SARRD_CMD_POWER_DOWN)  ? PDN_EDGES :
                                  (in_cmd == SARRD_CMD_SHORT_DUMMY) ? SHORT_DUMMY :
                                  (in_cmd == SARRD_CMD_DUMMY)       ? FULL_EDGES :
                                  conv_edges;
  // falling-edge capture takes the bit driven by the previous falling edge; rising capture
  // misses the first leading zero but ends on the same last bit, so no realignment
  wire logic        cap_en      = rise_capture ? rise_en : fall_en;
  wire logic        in_frame    = (state == SARRD_FRAME);
  // select rises one core cycle after the last falling edge, never on it, so the
  // converter has counted that edge before it sees the frame end
  wire logic        frame_end   = in_frame && (edges == target);
  wire logic [4:0]  pad         = FULL_EDGES - target;
  wire logic [15:0] full_word   = shreg << pad;
  wire logic        gap_done    = (gap_cnt == 6'(SAMPLE_TRACK_CYC));
  wire logic        take        = req_valid && req_ready;

  // ==========================================================================
  // sequencer
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      state          <= SARRD_IDLE;
      cmd            <= SARRD_CMD_CONVERT;
      target         <= 5'h0;
      gap_cnt        <= 6'h0;
      run            <= 1'b0;
      req_ready      <= 1'b0;
      rsp_valid      <= 1'b0;
      rsp_data       <= 12'h0;
      powered_down   <= 1'b0;
      frame_select_n <= 1'b1;
    end
    else
    begin
      rsp_valid <= 1'b0;
      unique case (state)
        SARRD_IDLE:
        begin
          req_ready <= 1'b1;
          if (take)
          begin
            req_ready      <= 1'b0;
            cmd            <= in_cmd;
            target         <= next_target;
            frame_select_n <= 1'b0;
            state          <= SARRD_LEAD;
          end
        end
        SARRD_LEAD:
        begin
          // one core cycle here before the divider runs; the first pin clock fall comes six core cycles after select falls
          run   <= 1'b1;
          state <= SARRD_FRAME;
        end
        SARRD_FRAME:
        begin
          if (frame_end)
          begin
            // the pin clock is forced back high one core cycle after the divider stops
            run            <= 1'b0;
            frame_select_n <= 1'b1;
            gap_cnt        <= 6'h0;
            state          <= SARRD_GAP;
          end
        end
        SARRD_GAP:
        begin
          gap_cnt <= gap_cnt + 6'h1;
          if (gap_done)
            state <= SARRD_DONE;
        end
        SARRD_DONE:
        begin
          powered_down <= (cmd == SARRD_CMD_POWER_DOWN);
          if (cmd == SARRD_CMD_CONVERT)
          begin
            rsp_valid <= 1'b1;
            rsp_data  <= full_word[11:0];
          end
          state <= SARRD_IDLE;
        end
        // only reachable from a corrupted state code
        default:
        begin
          run            <= 1'b0;
          frame_select_n <= 1'b1;
          state          <= SARRD_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // capture shifter and falling-edge counter
  // cleared at every take so an aborted frame leaves no stale bits for the next word
  always_ff @(posedge core_clk)
  begin
    if (srst || take)
    begin
      edges <= 5'h0;
      shreg <= 16'h0;
    end
    else if (in_frame)
    begin
      if (cap_en)
        shreg <= {shreg[14:0], dout_sync};
      if (fall_en)
        edges <= edges + 5'h1;
    end
  end

  // ==========================================================================
  // serial clock pin
  // forced high once the divider stops, so the pin never lingers low between frames
  always_ff @(posedge core_clk)
  begin
    if (srst)
      ser_clk <= 1'b1;
    else
      ser_clk <= sclk_int || !run;
  end

  // ==========================================================================
  // data line synchroniser
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      dout_meta <= 1'b0;
      dout_sync <= 1'b0;
    end
    else
    begin
      dout_meta <= dout_line;
      dout_sync <= dout_meta;
    end
  end
endmodule // sarrd_host

// ---- sim/sarrd_host_properties.sv ----
/* checker for the serial readout host: frame, clock and answer timing.
   assumes it is bound to sarrd_host and sees only its ports. */
`timescale 1ns/1ps
module sarrd_host_properties
(
  input wire logic        core_clk,
  input wire logic        srst,
  input wire logic        req_valid,
  input wire logic [1:0]  req_cmd,
  input wire logic [1:0]  variant,
  input wire logic        rise_capture,
  input wire logic        req_ready,
  input wire logic        rsp_valid,
  input wire logic [11:0] rsp_data,
  input wire logic        powered_down,
  input wire logic        frame_select_n,
  input wire logic        ser_clk,
  input wire logic        dout_line
);
  // ==========================================================================
  // properties
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  chk_take_select: assert property (req_valid && req_ready |=> !frame_select_n && !req_ready)
    else $error("select not lowered after take");
  chk_busy_refuse: assert property (!frame_select_n |-> !req_ready)
    else $error("ready high inside a frame");
  chk_clk_idle: assert property (frame_select_n && $past(frame_select_n) |-> ser_clk)
    else $error("serial clock moves outside a frame");
  chk_first_fall: assert property ($fell(frame_select_n) |-> ##[1:8] !ser_clk)
    else $error("no serial clock after select fall");
  chk_high_phase: assert property ($rose(ser_clk) && !frame_select_n |=> ser_clk[*3])
    else $error("serial clock high phase too short");
  chk_quiet_gap: assert property ($rose(frame_select_n) |=> frame_select_n[*6])
    else $error("idle gap too short");
  chk_rsp_pulse: assert property (rsp_valid |=> !rsp_valid && req_ready)
    else $error("answer not a single pulse");
  chk_track_time: assert property (rsp_valid |-> frame_select_n && $past(frame_select_n, 6))
    else $error("answer before track time");
  cover property (rsp_valid);
  cover property ($rose(powered_down));
  cover property ($fell(powered_down));
endmodule // sarrd_host_properties

bind sarrd_host sarrd_host_properties i_sarrd_host_properties (.core_clk(core_clk), .srst(srst),
  .req_valid(req_valid), .req_cmd(req_cmd), .variant(variant), .rise_capture(rise_capture),
  .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
  .powered_down(powered_down), .frame_select_n(frame_select_n), .ser_clk(ser_clk),
  .dout_line(dout_line));

// ---- sim/sarrd_adc_model.sv ----
/* behavioural converter: shifts four leading zeros then the 12-bit sample MSB first, no trailing zeros.
   assumes the host makes select and clock; released line shows the inverse level. */
`timescale 1ns/1ps
module sarrd_adc_model
(
  input  wire logic        frame_select_n,
  input  wire logic        ser_clk,
  input  wire logic [11:0] sample,
  output logic             dout_line
);
  // ==========================================================================
  // shifter and power state
  logic [15:0] shreg;
  int          falls;
  logic        pdn;
  initial
  begin
    dout_line = 1'b1;
    falls     = 0;
    pdn       = 1'b0; // supply power-up: tracking, normal mode
  end
  always @(negedge frame_select_n) // hold, sample, first zero
  begin
    shreg     = {4'h0, sample};
    falls     = 0;
    dout_line = 1'b0;
  end
  // no pull on the line, so a release drives the inverse of the last bit
  always @(negedge ser_clk)
  begin
    if (!frame_select_n)
    begin
      falls     = falls + 1;
      shreg     = shreg << 1;
      dout_line = (falls < 16) ? shreg[15] : ~dout_line;
    end
  end
  always @(posedge frame_select_n)
  begin
    if (falls >= 2 && falls < 10)
      pdn = 1'b1;
    else if (falls >= 10)
      pdn = 1'b0;
    if (falls < 16)
      dout_line = ~dout_line;
  end
endmodule // sarrd_adc_model

// ---- sim/tb_sarrd_host.sv ----
/* testbench for sarrd_host: power-mode frames and conversions of all variants.
   assumes sarrd_adc_model on the far side and the bound checker. */
`timescale 1ns/1ps
module tb_sarrd_host;
  logic        core_clk, srst, req_valid, rise_capture, req_ready, rsp_valid, got_rsp;
  logic        powered_down, frame_select_n, ser_clk, dout_line;
  logic [1:0]  req_cmd, variant;
  logic [11:0] rsp_data, sample, got;
  int          miscompares, num_checks;
  sarrd_host i_sarrd_host (.core_clk(core_clk), .srst(srst), .req_valid(req_valid),
    .req_cmd(req_cmd), .variant(variant), .rise_capture(rise_capture), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .powered_down(powered_down),
    .frame_select_n(frame_select_n), .ser_clk(ser_clk), .dout_line(dout_line));
  sarrd_adc_model i_sarrd_adc_model (.frame_select_n(frame_select_n), .ser_clk(ser_clk),
    .sample(sample), .dout_line(dout_line));
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // ==========================================================================
  // shared tasks
  task check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task tally_and_finish;
    if (miscompares == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // bounded wait for ready, catching any answer pulse on the way
  task wait_ready;
    int n;
    n = 0;
    while (!req_ready && n < 600)
    begin
      @(posedge core_clk);
      #1;
      n++;
      if (rsp_valid)
      begin
        got_rsp = 1'b1;
        got     = rsp_data;
      end
    end
    if (n >= 600)
    begin
      miscompares++;
      tally_and_finish;
    end
  endtask
  task run(input logic [1:0] cmd, input logic [1:0] v);
    wait_ready;
    got_rsp = 1'b0;
    @(posedge core_clk);
    req_cmd   <= cmd;
    variant   <= v;
    req_valid <= 1'b1;
    @(posedge core_clk);
    req_valid <= 1'b0;
    #1;
    wait_ready;
  endtask
  // ==========================================================================
  // scenarios
  task scen_power;
    run(2'h3, 2'h0);
    check(16'(i_sarrd_adc_model.falls), 16'h0005);
    check({14'h0, powered_down, i_sarrd_adc_model.pdn}, 16'h0003);
    run(2'h2, 2'h0);
    check(16'(i_sarrd_adc_model.falls), 16'h000a);
    check({14'h0, powered_down, i_sarrd_adc_model.pdn}, 16'h0000);
    run(2'h1, 2'h0);
    check({i_sarrd_adc_model.falls[14:0], got_rsp}, 16'h0020);
  endtask
  task scen_convert;
    logic [11:0] mask;
    for (int v = 0; v < 3; v++)
    begin
      for (int rc = 0; rc < 2; rc++)
      begin
        mask   = (v == 0) ? 12'hfff : (v == 1) ? 12'hffc : 12'hff0;
        sample = (rc == 1 ? 12'h9e7 : 12'h61b) & mask;
        @(posedge core_clk);
        rise_capture <= rc[0];
        run(2'h0, v[1:0]);
        check({3'h0, got_rsp, got}, {4'h1, sample});
        check(16'(i_sarrd_adc_model.falls), 16'(16 - 2 * v));
        check({15'h0, powered_down}, 16'h0000);
      end
    end
  endtask
  initial
  begin
    srst         = 1'b1;
    req_valid    = 1'b0;
    req_cmd      = 2'h0;
    variant      = 2'h0;
    rise_capture = 1'b0;
    sample       = 12'h000;
    got          = 12'h000;
    got_rsp      = 1'b0;
    miscompares  = 0;
    num_checks   = 0;
    repeat (7) @(posedge core_clk);
    #1;
    check({11'h0, frame_select_n, ser_clk, req_ready, rsp_valid, powered_down}, 16'h0018);
    @(posedge core_clk);
    srst <= 1'b0;
    scen_power;
    scen_convert;
    tally_and_finish;
  end
endmodule // tb_sarrd_host
